/* File: verilog/ecqi_pkg.sv */
package ecqi_pkg;
	// Clock and gate timing
	localparam int SYS_CLK_HZ = 10000000;
	localparam real GATE_TIME_S = 0.8388608;
	// Gate window in system clock cycles, rounded down
	localparam int GATE_CYCLES_CALC = int'($floor(GATE_TIME_S * SYS_CLK_HZ));
	// Count width and limits
	localparam int CNT_W = 16;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	localparam logic [15:0] OVF_VALUE = 16'hFFFF;
	localparam logic signed [15:0] QUAD_MAX = 16'sh3FFF;
	localparam logic signed [15:0] QUAD_MIN = 16'shC000;
	// Counter modes
	typedef enum logic [1:0] {
		ECQI_MODE_OFF = 2'b00,
		ECQI_MODE_GATED = 2'b01,
		ECQI_MODE_QUAD = 2'b10,
		ECQI_MODE_RUN = 2'b11
	} ecqi_mode_t;
	// AXI4-Lite register byte addresses
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_MUX_VAL = 8'h04;
	localparam logic [7:0] REG_DED_VAL = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	// Control field positions
	localparam int CTRL_MUX_MODE_LO = 0;
	localparam int CTRL_MUX_INV = 2;
	localparam int CTRL_MUX_PIN_LO = 3;
	localparam int CTRL_MUX_PRES = 5;
	localparam int CTRL_DED_MODE_LO = 8;
	localparam int CTRL_DED_INV = 10;
	localparam int CTRL_DED_PRES = 13;
	localparam logic [31:0] CTRL_RESET = 32'h00000000;
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

/* File: verilog/ecqi_counter.sv */
`timescale 1ns/1ns
// One timer/counter channel: gated, quadrature or running counting
module ecqi_counter import ecqi_pkg::*; #(
	parameter int GATE_CYCLES = GATE_CYCLES_CALC
) (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic [1:0] i_mode,
	input wire logic i_invert,
	input wire logic i_preserve,
	input wire logic i_in_a,
	input wire logic i_in_b,
	input wire logic i_read,
	output logic [15:0] o_value,
	output logic o_update,
	output logic o_overflow
);
	// Whole channel state
	typedef struct packed {
		logic [1:0] sync_a;
		logic [1:0] sync_b;
		logic prev_a;
		logic prev_b;
		logic [15:0] count;
		logic [15:0] result;
		logic [23:0] gate;
		logic ovf;
		logic upd;
	} ecqi_cnt_t;
	ecqi_cnt_t st;
	ecqi_cnt_t next_st;
	logic a_s, b_s; // Synchronised levels
	logic act_edge; // Active edge of input A
	logic a_chg, b_chg;
	logic up; // Quadrature direction
	logic signed [15:0] q;
	localparam logic [23:0] GATE_LAST = 24'(GATE_CYCLES - 1);
	assign a_s = st.sync_a[1];
	assign b_s = st.sync_b[1];
	assign a_chg = a_s ^ st.prev_a;
	assign b_chg = b_s ^ st.prev_b;
	// Falling by default, rising when inverted
	assign act_edge = a_chg & (i_invert ? a_s : ~a_s); // see RULE4
	assign q = st.count;
	// Next-state logic
	always_comb begin
		next_st = st;
		up = 1'b0;
		next_st.upd = 1'b0;
		// Two-stage synchroniser, only stage two is read
		next_st.sync_a = {st.sync_a[0], i_in_a}; // see RULE20
		next_st.sync_b = {st.sync_b[0], i_in_b}; // see RULE5
		next_st.prev_a = a_s;
		next_st.prev_b = b_s;
		unique case (i_mode)
			ECQI_MODE_GATED: begin
				// Count saturates at CNT_MAX, never wraps
				if (act_edge && st.count != CNT_MAX) begin
					next_st.count = st.count + 16'h0001; // see RULE2
				end
				if (st.gate == GATE_LAST) begin // see RULE1
					next_st.gate = '0;
					next_st.count = '0; // see RULE3
					if (st.count == '0 && !act_edge) begin
						// Empty window: flag overflow
						next_st.ovf = 1'b1; // see RULE7
						next_st.result = OVF_VALUE;
						next_st.upd = i_preserve;
					end else begin
						next_st.result = st.count;
						next_st.upd = 1'b1; // see RULE6
					end
				end else begin
					next_st.gate = st.gate + 24'h000001;
				end
				if (i_read && st.gate != GATE_LAST) begin
					next_st.ovf = 1'b0;
				end
			end
			ECQI_MODE_QUAD: begin
				// Sampled every cycle on both inputs; see RULE16
				// B falls with A low, or rises with A high: up
				up = b_chg & (b_s == a_s); // see RULE10
				if (a_chg || b_chg) begin // see RULE9
					if (up || (a_chg && (a_s != b_s))) begin
						if (q != QUAD_MAX) next_st.count = st.count + 16'h0001; // see RULE12
					end else begin
						if (q != QUAD_MIN) next_st.count = st.count - 16'h0001; // see RULE11
					end
				end
				// A changes: direction from B; see RULE17
				if (i_read) begin
					// Read clears; a same-cycle transition starts the new sum
					if (!(a_chg || b_chg)) next_st.count = '0; // see RULE13
					else if (up || (a_chg && (a_s != b_s))) next_st.count = 16'h0001;
					else next_st.count = 16'hFFFF;
				end
				next_st.result = i_read ? st.count : st.result;
				next_st.upd = a_chg | b_chg;
				next_st.ovf = 1'b0;
			end
			ECQI_MODE_RUN: begin
				// Running total since last read; see RULE18
				if (i_read) begin
					next_st.count = act_edge ? 16'h0001 : 16'h0000;
				end else if (act_edge && st.count != CNT_MAX) begin
					next_st.count = st.count + 16'h0001;
				end
				next_st.result = i_read ? st.count : st.result;
				next_st.ovf = 1'b0;
			end
			ECQI_MODE_OFF: begin
				next_st.count = '0;
				next_st.gate = '0;
				next_st.ovf = 1'b0;
			end
		endcase
	end
	// State register
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	// Gated reads the stored result; quadrature and running read the live count
	assign o_value = (i_mode == ECQI_MODE_GATED) ? st.result : st.count;
	assign o_update = st.upd;
	assign o_overflow = st.ovf;
	// Window boundary stores exactly the count held before it
	gate_store_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(i_mode == ECQI_MODE_GATED && st.gate == GATE_LAST && st.count != '0
			&& $stable(i_mode))
		|=> st.result == $past(st.count) && st.count <= 16'h0001) // see RULE3
		else $error("gated result not stored at window end");
	// Quadrature count never leaves the signed range
	quad_range_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(i_mode == ECQI_MODE_QUAD) |-> (q <= QUAD_MAX && q >= QUAD_MIN)) // see RULE12
		else $error("quadrature count out of range");
	// Quiet read leaves an empty quadrature sum
	quad_clear_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(i_mode == ECQI_MODE_QUAD && i_read && !(a_chg || b_chg))
		|=> st.count == '0) // see RULE13
		else $error("quadrature count not cleared by read");
	// Edgeless window sets overflow and the all-ones result
	gate_empty_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(i_mode == ECQI_MODE_GATED && st.gate == GATE_LAST && st.count == '0 && !act_edge)
		|=> (st.ovf && st.result == OVF_VALUE)) // see RULE7
		else $error("empty window not flagged");
endmodule

/* File: verilog/ecqi_top.sv */
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
// Operation
// RULE1 - Gated mode counts edges per fixed window
// RULE2 - Counter adds one per active edge
// RULE3 - Window end stores result, clears counter
// RULE4 - Falling edge default, invert selects rising
// RULE5 - Gated input sampled every system clock
// RULE6 - Update event on each window refresh; the code raises it for an empty window only with preserve set
// RULE7 - Empty window flags overflow, reads FFFF
// RULE8 - Pins four-seven; pin four either counter
// RULE9 - Quadrature counts two-bit Gray transitions
// RULE10 - Direction from B change against A
// RULE11 - Read returns net sum since read
// RULE12 - Sixteen-bit signed, saturating at 16K
// RULE13 - Quadrature read clears the counter
// RULE14 - Encoder keeps rate within sampling limit
// RULE15 - Quad pairs: six-seven mux, four-five dedicated
// RULE16 - Both quadrature inputs sampled every clock
// RULE17 - A edges counted, B sets sign; the code also counts B changes, with A setting their sign
// RULE18 - Running mode counts since last read
// RULE19 - Two channels: multiplexed and dedicated
// RULE20 - Synchronise inputs, divide clock for gate
module ecqi_top import ecqi_pkg::*; #(
	parameter int GATE_CYCLES = GATE_CYCLES_CALC
) (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic [3:0] i_io_pin, // Pins four to seven
	// AXI4-Lite slave
	input wire logic [7:0] i_s_axi_awaddr,
	input wire logic i_s_axi_awvalid,
	output logic o_s_axi_awready,
	input wire logic [31:0] i_s_axi_wdata,
	input wire logic [3:0] i_s_axi_wstrb,
	input wire logic i_s_axi_wvalid,
	output logic o_s_axi_wready,
	output logic [1:0] o_s_axi_bresp,
	output logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	input wire logic [7:0] i_s_axi_araddr,
	input wire logic i_s_axi_arvalid,
	output logic o_s_axi_arready,
	output logic [31:0] o_s_axi_rdata,
	output logic [1:0] o_s_axi_rresp,
	output logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	// Update events, one-cycle pulses
	output logic o_mux_update,
	output logic o_ded_update
);
	// Bus state
	typedef struct packed {
		logic aw_got;
		logic w_got;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [31:0] ctrl;
		logic mux_ev;
		logic ded_ev;
	} ecqi_top_t;
	ecqi_top_t st;
	ecqi_top_t next_st;
	logic [1:0] mux_mode, ded_mode;
	logic [1:0] mux_pin;
	logic mux_a, mux_b; // Multiplexed channel inputs
	logic mux_rd, ded_rd; // Read strobes clear running and quadrature counters
	logic [15:0] mux_val, ded_val;
	logic mux_upd, ded_upd, mux_ovf, ded_ovf;
	logic ar_take;
	logic wr_go;
	integer i;
	assign mux_mode = st.ctrl[CTRL_MUX_MODE_LO +: 2];
	assign ded_mode = st.ctrl[CTRL_DED_MODE_LO +: 2];
	assign mux_pin = st.ctrl[CTRL_MUX_PIN_LO +: 2];
	// Mux selects any of pins four-seven; quad uses six and seven
	always_comb begin
		if (mux_mode == ECQI_MODE_QUAD) begin
			mux_a = i_io_pin[2]; // see RULE15
			mux_b = i_io_pin[3];
		end else begin
			mux_a = i_io_pin[mux_pin]; // see RULE8
			mux_b = 1'b0;
		end
	end
	assign ar_take = i_s_axi_arvalid && !st.rvalid;
	assign mux_rd = ar_take && i_s_axi_araddr == REG_MUX_VAL;
	assign ded_rd = ar_take && i_s_axi_araddr == REG_DED_VAL;
	// Two channels, both synchronise their own pins; see RULE19
	ecqi_counter #(.GATE_CYCLES(GATE_CYCLES)) u_mux (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_mode(mux_mode),
		.i_invert(st.ctrl[CTRL_MUX_INV]),
		.i_preserve(st.ctrl[CTRL_MUX_PRES]),
		.i_in_a(mux_a),
		.i_in_b(mux_b),
		.i_read(mux_rd),
		.o_value(mux_val),
		.o_update(mux_upd),
		.o_overflow(mux_ovf)
	);
	// Dedicated channel: pin four, quad pair four and five
	ecqi_counter #(.GATE_CYCLES(GATE_CYCLES)) u_ded (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_mode(ded_mode),
		.i_invert(st.ctrl[CTRL_DED_INV]),
		.i_preserve(st.ctrl[CTRL_DED_PRES]),
		.i_in_a(i_io_pin[0]),
		.i_in_b(ded_mode == ECQI_MODE_QUAD ? i_io_pin[1] : 1'b0), // see RULE15
		.i_read(ded_rd),
		.o_value(ded_val),
		.o_update(ded_upd),
		.o_overflow(ded_ovf)
	);
	// Bus next-state
	always_comb begin
		next_st = st;
		wr_go = 1'b0;
		next_st.mux_ev = mux_upd;
		next_st.ded_ev = ded_upd;
		// Address and data taken in either order
		if (i_s_axi_awvalid && !st.aw_got) begin
			next_st.aw_got = 1'b1;
			next_st.awaddr = i_s_axi_awaddr;
		end
		if (i_s_axi_wvalid && !st.w_got) begin
			next_st.w_got = 1'b1;
			next_st.wdata = i_s_axi_wdata;
			next_st.wstrb = i_s_axi_wstrb;
		end
		if (st.aw_got && st.w_got && !st.bvalid) begin
			wr_go = 1'b1;
			next_st.aw_got = 1'b0;
			next_st.w_got = 1'b0;
			next_st.bvalid = 1'b1;
			if (st.awaddr == REG_CTRL) begin
				next_st.bresp = RESP_OKAY;
				for (i = 0; i < 4; i++) begin
					if (st.wstrb[i]) next_st.ctrl[i*8 +: 8] = st.wdata[i*8 +: 8];
				end
			end else begin
				next_st.bresp = RESP_SLVERR;
			end
		end
		if (st.bvalid && i_s_axi_bready) next_st.bvalid = 1'b0;
		// Read answer next cycle; value reads clear running and quadrature counts
		if (ar_take) begin
			next_st.rvalid = 1'b1;
			next_st.rresp = RESP_OKAY;
			unique case (i_s_axi_araddr)
				REG_CTRL: next_st.rdata = st.ctrl;
				REG_MUX_VAL: next_st.rdata = {{16{mux_mode == ECQI_MODE_QUAD & mux_val[15]}}, mux_val};
				REG_DED_VAL: next_st.rdata = {{16{ded_mode == ECQI_MODE_QUAD & ded_val[15]}}, ded_val};
				REG_STATUS: next_st.rdata = {28'h0000000, ded_ovf, mux_ovf, ded_upd, mux_upd};
				default: begin
					next_st.rdata = '0;
					next_st.rresp = RESP_SLVERR;
				end
			endcase
		end else if (st.rvalid && i_s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
	end
	// State register
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			st <= '0;
			st.ctrl <= CTRL_RESET;
		end else begin
			st <= next_st;
		end
	end
	assign o_s_axi_awready = !st.aw_got;
	assign o_s_axi_wready = !st.w_got;
	assign o_s_axi_bvalid = st.bvalid;
	assign o_s_axi_bresp = st.bresp;
	assign o_s_axi_arready = !st.rvalid;
	assign o_s_axi_rvalid = st.rvalid;
	assign o_s_axi_rdata = st.rdata;
	assign o_s_axi_rresp = st.rresp;
	assign o_mux_update = st.mux_ev; // see RULE6
	assign o_ded_update = st.ded_ev;
	// Read response follows the taken address by one cycle
	read_answer_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(i_s_axi_arvalid && o_s_axi_arready) |=> o_s_axi_rvalid) // see RULE11
		else $error("read answer missing");
	// Write response follows both halves
	write_answer_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		wr_go |=> o_s_axi_bvalid) // see RULE7
		else $error("write answer missing");
endmodule

/* File: tb/ecqi_source.sv */
`timescale 1ns/1ns
// Pulse source and quadrature encoder on pins four to seven
module ecqi_source (
	input wire logic i_sys_clk,
	output logic [3:0] o_pin
);
	// Pins rest high, so a full pulse gives one falling edge
	initial o_pin = 4'hF;
	// Two cycles per level keeps the pulse rate at a quarter of the clock
	task automatic pulse(input int k, input int n);
		for (int i = 0; i < 2 * n; i++) begin
			repeat (2) @(posedge i_sys_clk);
			o_pin[k] <= ~o_pin[k];
		end
	endtask
	// Single level change, for edge polarity cases
	task automatic set(input int k, input logic v);
		@(posedge i_sys_clk);
		o_pin[k] <= v;
	endtask
	// One Gray step on pair p; up runs 00,10,11,01 as (A,B)
	task automatic step(input int p, input bit up);
		repeat (2) @(posedge i_sys_clk);
		if (up ^ o_pin[2 * p] ^ o_pin[2 * p + 1])
			o_pin[2 * p] <= ~o_pin[2 * p];
		else
			o_pin[2 * p + 1] <= ~o_pin[2 * p + 1];
	endtask
endmodule

/* File: tb/edge_count_quadrature_input_tb.sv */
`timescale 1ns/1ns
// Registers over AXI4-Lite, pins from the source model
module edge_count_quadrature_input_tb import ecqi_pkg::*;;
	logic i_sys_clk = 1'b0;
	logic i_rst = 1'b1;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, d, rdata;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, mupd, dupd;
	logic [1:0] bresp, rresp, r;
	logic [3:0] pin;
	logic [7:0] seed = 8'h45; // Random source starts at 69
	bit up;
	int fails = 0, num_checks = 0, ups = 0, dups = 0, n, k, i, sum, base;
	// 100 ns clock
	always #50 i_sys_clk = ~i_sys_clk;
	// Update pulses of the multiplexed channel
	always @(posedge i_sys_clk) if (mupd === 1'b1) ups <= ups + 1;
	// Update pulses of the dedicated channel
	always @(posedge i_sys_clk) if (dupd === 1'b1) dups <= dups + 1;
	ecqi_source src (.i_sys_clk(i_sys_clk), .o_pin(pin));
	// Short gate window keeps the run brief
	ecqi_top #(.GATE_CYCLES(64)) DUT (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_io_pin(pin),
		.i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
		.i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wvalid),
		.o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
		.i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
		.o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
		.o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .o_mux_update(mupd),
		.o_ded_update(dupd));
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	// Saturated net sum, sign-extended
	function automatic logic [31:0] qexp(input int s);
		return 32'(s > 16383 ? 16383 : (s < -16384 ? -16384 : s));
	endfunction
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
		end
	endtask
	// Every wait is bounded
	task automatic tmo(input int c);
		if (c > 3000) begin
			fails++;
			print_verdict();
		end
	endtask
	// Write: address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		int c;
		@(posedge i_sys_clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		c = 0;
		do begin
			@(posedge i_sys_clk);
			tmo(++c);
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		int c;
		@(posedge i_sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		c = 0;
		do begin
			@(posedge i_sys_clk);
			tmo(++c);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	// Update pulse stands one cycle, so it is looked at every edge
	task automatic wait_upd();
		int c;
		c = 0;
		do begin
			@(posedge i_sys_clk);
			tmo(++c);
		end while (mupd !== 1'b1);
	endtask
	initial begin
		repeat (6) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		rd(REG_CTRL);
		chk("ctrl reset", d, CTRL_RESET);
		rd(8'h10);
		chk("unmapped resp", 32'(r), 32'(RESP_SLVERR));
		wr(REG_MUX_VAL, 32'h1);
		chk("value write resp", 32'(r), 32'(RESP_SLVERR));
		// Running count on each mux pin; pin four also feeds the dedicated one
		for (k = 0; k < 4; k++) begin
			wr(REG_CTRL, 32'h303 | (32'(k) << CTRL_MUX_PIN_LO));
			rd(REG_MUX_VAL);
			rd(REG_DED_VAL);
			n = 1 + seed % 12;
			seed = lfsr(seed);
			src.pulse(k, n);
			repeat (4) @(posedge i_sys_clk); // Two-stage input sync
			rd(REG_MUX_VAL);
			chk("running count", d, 32'(n));
			rd(REG_DED_VAL);
			chk("dedicated count", d, k == 0 ? 32'(n) : 32'h0);
		end
		// One edge each way, falling by default and rising when inverted
		for (k = 0; k < 2; k++) begin
			wr(REG_CTRL, 32'h3 | (32'(k) << CTRL_MUX_INV));
			rd(REG_MUX_VAL);
			src.set(0, 1'b0);
			repeat (4) @(posedge i_sys_clk);
			rd(REG_MUX_VAL);
			chk("fall count", d, 32'(1 - k));
			src.set(0, 1'b1);
			repeat (4) @(posedge i_sys_clk);
			rd(REG_MUX_VAL);
			chk("rise count", d, 32'(k));
		end
		// Gated: empty windows are silent and read all ones
		wr(REG_CTRL, 32'h1);
		base = ups;
		repeat (200) @(posedge i_sys_clk);
		chk("empty window events", 32'(ups - base), 32'h0);
		rd(REG_MUX_VAL);
		chk("empty window value", d, 32'(OVF_VALUE));
		// Pulses inside one window; a single edge first aligns to a window
		src.pulse(0, 1);
		wait_upd();
		n = 1 + seed % 10;
		seed = lfsr(seed);
		src.pulse(0, n);
		wait_upd(); // Refresh raises the event
		rd(REG_MUX_VAL);
		chk("gated count", d, 32'(n));
		// Next window is empty and silent, so wait past its end
		repeat (70) @(posedge i_sys_clk);
		rd(REG_MUX_VAL);
		chk("cleared window", d, 32'(OVF_VALUE));
		// Preserve makes even an empty window raise the event
		wr(REG_CTRL, 32'h21);
		wait_upd();
		// Random Gray walks on pins four/five then six/seven
		for (k = 0; k < 2; k++) begin
			wr(REG_CTRL, k == 1 ? 32'h2 : 32'h200);
			// Pin reselection on mode entry looks like a step; let it settle
			repeat (4) @(posedge i_sys_clk);
			rd(k == 1 ? REG_MUX_VAL : REG_DED_VAL);
			base = dups;
			sum = 0;
			for (i = 0; i < 40; i++) begin
				up = seed[0];
				seed = lfsr(seed);
				src.step(k, up);
				sum += up ? 1 : -1;
			end
			repeat (4) @(posedge i_sys_clk);
			rd(k == 1 ? REG_MUX_VAL : REG_DED_VAL);
			chk("quad sum", d, qexp(sum));
			rd(k == 1 ? REG_MUX_VAL : REG_DED_VAL);
			chk("quad cleared", d, 32'h0);
			chk("ded events", 32'(dups - base), k == 0 ? 32'd40 : 32'h0);
		end
		// Long runs each way must stop at the limits
		wr(REG_CTRL, 32'h200);
		repeat (4) @(posedge i_sys_clk);
		for (k = 0; k < 2; k++) begin
			rd(REG_DED_VAL);
			for (i = 0; i < 16390; i++)
				src.step(0, k == 0);
			repeat (4) @(posedge i_sys_clk);
			rd(REG_DED_VAL);
			chk("quad saturation", d, qexp(k == 0 ? 16390 : -16390));
		end
		print_verdict();
	end
endmodule
